// ### hpd_pin_ctrl.sv
// Purpose: Pin control of the main data bus, address pins and host byte pins.
// Assumes: Pins pass hpd_sync3; core and memory side share clk_sys.
// Notes: Pin levels are resolved outside from out, oe_n and keeper_on.
// Contract
// - In wide mode the host addresses internal memory through the sixteen address pins.
// - In wide mode the host reads and writes internal memory over the sixteen data pins.
// - The main data bus is shared between core, external memory and I/O, and the host port.
// - The main data bus floats when not outputting, in reset, or under bus takeover.
// - The main data bus floats whenever the global float input is low.
// - An undriven bus with its keeper enabled holds the level last driven.
// - Main bus keepers are off at reset and then follow the main keeper enable bit.
// - Host byte keepers are off at reset and then follow the host keeper enable bit.
// - In wide mode the host byte pins serve as general-purpose I/O.
// - The host byte bus floats when not outputting or when the float input is low.
// - A high wide mode select chooses the non-multiplexed mode with no host interrupts.
// - The host port enable strap is sampled after reset; if low the port stays off.
`timescale 1ns/1ps
`default_nettype none
`include "hpd_defs.svh"

module hpd_pin_ctrl (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic wide_mode_select,
	input wire logic host_port_strap_enable,
	input wire logic float_n,
	input wire logic takeover_req,
	input wire logic host_cs_n,
	input wire logic host_rw,
	input wire logic host_strobe_n,
	input wire logic [`HPD_ADDR_W-1:0] wide_address_pins,
	input wire logic [`HPD_DATA_W-1:0] main_data_pins_in,
	input wire logic [`HPD_BYTE_W-1:0] host_byte_pins_in,
	input wire logic main_keeper_enable,
	input wire logic host_keeper_enable,
	input wire logic core_drive,
	input wire logic [`HPD_DATA_W-1:0] core_wdata,
	input wire logic host_byte_drive,
	input wire logic [`HPD_BYTE_W-1:0] host_byte_wdata,
	input wire logic [`HPD_BYTE_W-1:0] gpio_out,
	input wire logic [`HPD_BYTE_W-1:0] gpio_dir,
	input wire logic mem_rvalid,
	input wire logic [`HPD_DATA_W-1:0] mem_rdata,
	output hpd_pkg::hpd_main_pins_t main_pins_q,
	output hpd_pkg::hpd_byte_pins_t byte_pins_q,
	output hpd_pkg::hpd_mem_req_t mem_req_q,
	output logic [`HPD_DATA_W-1:0] main_data_rd_q,
	output logic [`HPD_BYTE_W-1:0] gpio_in_q,
	output logic core_grant_q,
	output logic host_port_en_q,
	output logic wide_mode_q
);
	import hpd_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [`HPD_CTRL_W-1:0] ctrl_s;
	logic [`HPD_ADDR_W-1:0] addr_s;
	logic [`HPD_DATA_W-1:0] data_s;
	logic [`HPD_BYTE_W-1:0] byte_s;

	hpd_sync3 #(.WIDTH(`HPD_CTRL_W), .RST_VAL(`HPD_CTRL_RST)) u_sync_ctrl (
		.clk_sys(clk_sys),
		.reset(reset),
		.pin_in({host_strobe_n, host_rw, host_cs_n, takeover_req, float_n,
			host_port_strap_enable, wide_mode_select}),
		.stable_q(ctrl_s)
	);

	hpd_sync3 #(.WIDTH(`HPD_ADDR_W), .RST_VAL(`HPD_DATA_RST)) u_sync_addr (
		.clk_sys(clk_sys),
		.reset(reset),
		.pin_in(wide_address_pins),
		.stable_q(addr_s)
	);

	hpd_sync3 #(.WIDTH(`HPD_DATA_W), .RST_VAL(`HPD_DATA_RST)) u_sync_data (
		.clk_sys(clk_sys),
		.reset(reset),
		.pin_in(main_data_pins_in),
		.stable_q(data_s)
	);

	hpd_sync3 #(.WIDTH(`HPD_BYTE_W), .RST_VAL(`HPD_BYTE_RST)) u_sync_byte (
		.clk_sys(clk_sys),
		.reset(reset),
		.pin_in(host_byte_pins_in),
		.stable_q(byte_s)
	);

	logic wide_s;
	logic strap_s;
	logic float_n_s;
	logic takeover_s;
	logic cs_n_s;
	logic rw_s;
	logic strobe_n_s;

	assign wide_s = ctrl_s[`HPD_C_WIDE];
	assign strap_s = ctrl_s[`HPD_C_STRAP];
	assign float_n_s = ctrl_s[`HPD_C_FLOAT_N];
	assign takeover_s = ctrl_s[`HPD_C_TAKEOVER];
	assign cs_n_s = ctrl_s[`HPD_C_CS_N];
	assign rw_s = ctrl_s[`HPD_C_RW];
	assign strobe_n_s = ctrl_s[`HPD_C_STROBE_N];

	////////////////////////////////////////////////////////////////////////////
	// Strap capture after reset release

	logic [2:0] strap_cnt_q;
	logic [2:0] strap_cnt_d;
	logic strap_done_q;
	logic strap_done_d;
	logic host_port_en_d;

	// Waits for the synchroniser to fill so the strap is not read as its reset value
	always_comb begin
		strap_cnt_d = strap_cnt_q;
		strap_done_d = strap_done_q;
		host_port_en_d = host_port_en_q;
		if (!strap_done_q) begin
			if (strap_cnt_q == `HPD_STRAP_WAIT) begin
				strap_done_d = 1'b1;
				host_port_en_d = strap_s;
			end else begin
				strap_cnt_d = strap_cnt_q + 3'h1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			strap_cnt_q <= 3'h0;
			strap_done_q <= 1'b0;
			host_port_en_q <= 1'b0;
		end else begin
			strap_cnt_q <= strap_cnt_d;
			strap_done_q <= strap_done_d;
			host_port_en_q <= host_port_en_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Host access in wide mode

	hpd_state_t state_q;
	hpd_state_t state_d;
	logic strobe_prev_q;
	logic [`HPD_DATA_W-1:0] hold_rdata_q;
	logic [`HPD_DATA_W-1:0] hold_rdata_d;
	hpd_mem_req_t mem_req_d;
	logic wide_active;
	logic strobe_fall;

	// Host interrupts do not exist in this mode, so none are raised
	assign wide_active = wide_s && host_port_en_q;
	assign strobe_fall = strobe_prev_q && !strobe_n_s && !cs_n_s;

	always_comb begin
		state_d = state_q;
		hold_rdata_d = hold_rdata_q;
		mem_req_d = mem_req_q;
		mem_req_d.req = 1'b0;
		unique case (state_q)
			HPD_IDLE: begin
				if (wide_active && strobe_fall) begin
					mem_req_d.addr = addr_s;
					if (rw_s) begin
						mem_req_d.req = 1'b1;
						mem_req_d.we = 1'b0;
						state_d = HPD_READ_WAIT;
					end else begin
						state_d = HPD_WRITE;
					end
				end
			end
			HPD_READ_WAIT: begin
				if (mem_rvalid) begin
					hold_rdata_d = mem_rdata;
					state_d = HPD_READ_DRIVE;
				end
			end
			HPD_READ_DRIVE: begin
				if (strobe_n_s) begin
					state_d = HPD_IDLE;
				end
			end
			HPD_WRITE: begin
				// Data is taken at the strobe's end, when the host has settled it
				if (strobe_n_s) begin
					mem_req_d.req = 1'b1;
					mem_req_d.we = 1'b1;
					mem_req_d.wdata = data_s;
					state_d = HPD_IDLE;
				end
			end
		endcase
		if (!wide_active && state_q != HPD_READ_WAIT) begin
			state_d = HPD_IDLE;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_q <= HPD_IDLE;
			strobe_prev_q <= 1'b1;
			hold_rdata_q <= `HPD_DATA_RST;
			mem_req_q <= '0;
		end else begin
			state_q <= state_d;
			strobe_prev_q <= strobe_n_s;
			hold_rdata_q <= hold_rdata_d;
			mem_req_q <= mem_req_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Main data bus

	hpd_main_pins_t main_pins_d;
	logic core_grant_d;
	logic host_drive;
	logic main_drive;

	// Host read data owns the bus while presented; the core waits on its grant
	assign host_drive = (state_q == HPD_READ_DRIVE);
	assign main_drive = (host_drive || core_drive) && float_n_s && !takeover_s;

	always_comb begin
		main_pins_d = main_pins_q;
		core_grant_d = !host_drive && (state_q == HPD_IDLE);
		main_pins_d.oe_n = !main_drive;
		if (main_drive) begin
			main_pins_d.out = host_drive ? hold_rdata_q : core_wdata;
		end
		// Out keeps the last driven word for the keeper
		main_pins_d.keeper_on = main_keeper_enable && !main_drive;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			main_pins_q <= '{out: `HPD_DATA_RST, oe_n: 1'b1, keeper_on: 1'b0};
			core_grant_q <= 1'b0;
			main_data_rd_q <= `HPD_DATA_RST;
			wide_mode_q <= 1'b0;
		end else begin
			main_pins_q <= main_pins_d;
			core_grant_q <= core_grant_d;
			main_data_rd_q <= data_s;
			wide_mode_q <= wide_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Host byte pins

	hpd_byte_pins_t byte_pins_d;
	logic [`HPD_BYTE_W-1:0] byte_drive;

	always_comb begin
		byte_pins_d = byte_pins_q;
		if (!float_n_s) begin
			byte_drive = '0;
		end else if (wide_s) begin
			byte_drive = gpio_dir;
		end else if (host_port_en_q && host_byte_drive) begin
			byte_drive = '1;
		end else begin
			byte_drive = '0;
		end
		byte_pins_d.oe_n = ~byte_drive;
		for (int i = 0; i < `HPD_BYTE_W; i++) begin
			if (byte_drive[i]) begin
				byte_pins_d.out[i] = wide_s ? gpio_out[i] : host_byte_wdata[i];
			end
		end
		byte_pins_d.keeper_on = host_keeper_enable ? ~byte_drive : '0;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			byte_pins_q <= '{out: `HPD_BYTE_RST, oe_n: 8'hFF, keeper_on: 8'h00};
			gpio_in_q <= `HPD_BYTE_RST;
		end else begin
			byte_pins_q <= byte_pins_d;
			gpio_in_q <= byte_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	float_main_a: assert property (!float_n_s |=> main_pins_q.oe_n)
		else $error("main bus driven while float low");
	takeover_main_a: assert property (takeover_s |=> main_pins_q.oe_n)
		else $error("main bus driven during takeover");
	idle_main_a: assert property (!host_drive && !core_drive |=> main_pins_q.oe_n)
		else $error("main bus driven with no source");
	keep_level_a: assert property (main_pins_q.oe_n && $past(main_pins_q.oe_n)
		|-> $stable(main_pins_q.out))
		else $error("main keeper level moved");
	main_keeper_a: assert property (main_pins_q.keeper_on |-> !main_pins_q.oe_n == 1'b0
		&& $past(main_keeper_enable))
		else $error("main keeper on without enable");
	host_keeper_a: assert property (byte_pins_q.keeper_on != 8'h00 |-> $past(host_keeper_enable))
		else $error("host keeper on without enable");
	float_byte_a: assert property (!float_n_s |=> byte_pins_q.oe_n == 8'hFF)
		else $error("host byte bus driven while float low");
	gpio_dir_a: assert property (wide_s && float_n_s |=> byte_pins_q.oe_n == ~$past(gpio_dir))
		else $error("gpio direction not followed");
	read_req_a: assert property (state_q == HPD_IDLE && wide_active && strobe_fall && rw_s
		|=> mem_req_q.req && !mem_req_q.we && mem_req_q.addr == $past(addr_s))
		else $error("host read request lost");
	write_req_a: assert property (state_q == HPD_WRITE && strobe_n_s
		|=> mem_req_q.req && mem_req_q.we && mem_req_q.wdata == $past(data_s))
		else $error("host write request lost");
	strap_hold_a: assert property (strap_done_q |=> $stable(host_port_en_q))
		else $error("host port enable moved after strap");
	no_host_a: assert property (!host_port_en_q |-> state_q == HPD_IDLE)
		else $error("host access with port disabled");

endmodule : hpd_pin_ctrl

`default_nettype wire

// ### hpd_defs.svh
// Purpose: Widths, reset values and timing counts of the host port pin control.
// Assumes: Included by the package, by hpd_pin_ctrl and by the host model.
// Notes: Definitions only.
`ifndef HPD_DEFS_SVH
`define HPD_DEFS_SVH

`define HPD_ADDR_W 16
`define HPD_DATA_W 16
`define HPD_BYTE_W 8
`define HPD_CTRL_W 7
`define HPD_CLK_PERIOD_NS 40
// Edges after reset release before the strap sample is trusted
`define HPD_STRAP_WAIT 3'h4
`define HPD_DATA_RST 16'h0000
`define HPD_BYTE_RST 8'h00
// Bit positions inside the synchronised control word
`define HPD_C_WIDE 0
`define HPD_C_STRAP 1
`define HPD_C_FLOAT_N 2
`define HPD_C_TAKEOVER 3
`define HPD_C_CS_N 4
`define HPD_C_RW 5
`define HPD_C_STROBE_N 6
// Idle levels: float, select and strobe inactive high
`define HPD_CTRL_RST 7'h54

`endif

// ### hpd_pkg.sv
// Purpose: Types shared by the host port pin control.
// Assumes: hpd_defs.svh holds the numbers.
// Notes: None.
`include "hpd_defs.svh"

package hpd_pkg;

	typedef enum logic [1:0] {
		HPD_IDLE = 2'b00,
		HPD_READ_WAIT = 2'b01,
		HPD_READ_DRIVE = 2'b10,
		HPD_WRITE = 2'b11
	} hpd_state_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [`HPD_ADDR_W-1:0] addr;
		logic [`HPD_DATA_W-1:0] wdata;
	} hpd_mem_req_t;

	typedef struct packed {
		logic [`HPD_DATA_W-1:0] out;
		logic oe_n;
		logic keeper_on;
	} hpd_main_pins_t;

	typedef struct packed {
		logic [`HPD_BYTE_W-1:0] out;
		logic [`HPD_BYTE_W-1:0] oe_n;
		logic [`HPD_BYTE_W-1:0] keeper_on;
	} hpd_byte_pins_t;

endpackage : hpd_pkg

// ### hpd_sync3.sv
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Input is asynchronous to clk_sys.
// Notes: A bit changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module hpd_sync3 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] stable_q
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] stable_d;

	always_comb begin
		stable_d = stable_q;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				stable_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			stable_q <= RST_VAL;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			stable_q <= stable_d;
		end
	end

endmodule : hpd_sync3

`default_nettype wire

// ### hpd_host_model.sv
// Purpose: Host processor model on the wide, non-multiplexed host port.
// Assumes: The bench calls write and read; one access at a time.
// Notes: Data and address lines change after release, never hold stale values.
`timescale 1ns/1ps
`default_nettype none
`include "hpd_defs.svh"

module hpd_host_model (
	input wire logic clk_sys,
	input wire hpd_pkg::hpd_main_pins_t main_pins_q,
	input wire logic [`HPD_DATA_W-1:0] bus_in,
	output logic host_cs_n,
	output logic host_rw,
	output logic host_strobe_n,
	output logic [`HPD_ADDR_W-1:0] host_addr,
	output logic host_drive,
	output logic [`HPD_DATA_W-1:0] host_wdata
);
	import hpd_pkg::*;
	initial begin
		{host_cs_n, host_rw, host_strobe_n, host_drive} = 4'hE;
		{host_addr, host_wdata} = '0;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step
	////////////////////////////////////////////////////////////////
	// Separate address and data lines, no interrupt handshake
	task automatic write(input logic [15:0] a, input logic [15:0] d);
		{host_addr, host_wdata, host_drive, host_rw, host_cs_n} = {a, d, 3'b100};
		step(1);
		host_strobe_n = 1'b0;
		step(8);
		host_strobe_n = 1'b1;
		// Data held past the synchroniser after the rising strobe
		step(6);
		{host_cs_n, host_drive, host_addr, host_wdata} = {2'b10, ~a, ~d};
		step(2);
	endtask : write
	task automatic read(input logic [15:0] a, output logic [15:0] d, output logic ok);
		ok = 1'b0;
		{host_addr, host_rw, host_cs_n} = {a, 2'b10};
		step(1);
		host_strobe_n = 1'b0;
		for (int n = 0; n < 60 && !ok; n++) begin
			step(1);
			ok = (main_pins_q.oe_n === 1'b0);
		end
		d = bus_in;
		host_strobe_n = 1'b1;
		step(6);
		{host_cs_n, host_addr} = {1'b1, ~a};
		step(2);
	endtask : read
endmodule : hpd_host_model
`default_nettype wire

// ### tb_top.sv
// Purpose: Self-checking bench of the host port pin control.
// Assumes: Memory answers four edges after a read request.
// Notes: Undriven main bus lines without a keeper show a changing pattern; undriven host byte lines without a keeper show ext_byte.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_top;
	import hpd_pkg::*;
	logic clk_sys, reset, wide_mode_select, host_port_strap_enable, float_n, takeover_req;
	logic host_cs_n, host_rw, host_strobe_n, host_drive, main_keeper_enable, host_keeper_enable;
	logic core_drive, host_byte_drive, mem_rvalid, ok, core_grant_q, host_port_en_q, wide_mode_q;
	logic [15:0] wide_address_pins, host_wdata, main_data_pins_in, core_wdata, mem_rdata;
	logic [15:0] last_q, ra, rd, rq, main_data_rd_q;
	logic [7:0] host_byte_pins_in, host_byte_wdata, gpio_out, gpio_dir, ext_byte, gpio_in_q;
	logic [2:0] rv_pipe;
	logic [32:0] e;
	logic [32:0] exp_q[$];
	hpd_main_pins_t main_pins_q;
	hpd_byte_pins_t byte_pins_q;
	hpd_mem_req_t mem_req_q;
	int num_errors, samples_checked;

	hpd_pin_ctrl dut_u (.clk_sys, .reset, .wide_mode_select, .host_port_strap_enable, .float_n,
		.takeover_req, .host_cs_n, .host_rw, .host_strobe_n, .wide_address_pins,
		.main_data_pins_in, .host_byte_pins_in, .main_keeper_enable, .host_keeper_enable,
		.core_drive, .core_wdata, .host_byte_drive, .host_byte_wdata, .gpio_out, .gpio_dir,
		.mem_rvalid, .mem_rdata, .main_pins_q, .byte_pins_q, .mem_req_q, .main_data_rd_q,
		.gpio_in_q, .core_grant_q, .host_port_en_q, .wide_mode_q);
	hpd_host_model host_u (.clk_sys, .main_pins_q, .bus_in(main_data_pins_in), .host_cs_n,
		.host_rw, .host_strobe_n, .host_addr(wide_address_pins), .host_drive, .host_wdata);

	////////////////////////////////////////////////////////////////
	assign main_data_pins_in = (main_pins_q.oe_n === 1'b0) ? main_pins_q.out :
		host_drive ? host_wdata : (main_pins_q.keeper_on === 1'b1) ? main_pins_q.out : ~last_q;
	assign host_byte_pins_in = ((~byte_pins_q.oe_n | byte_pins_q.keeper_on) & byte_pins_q.out)
		| ((byte_pins_q.oe_n & ~byte_pins_q.keeper_on) & ext_byte);
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		last_q <= main_data_pins_in;
		rv_pipe <= {rv_pipe[1:0], mem_req_q.req === 1'b1 && mem_req_q.we === 1'b0};
		if (mem_req_q.req === 1'b1) rq <= mem_req_q.addr;
		mem_rvalid <= rv_pipe[2];
		mem_rdata <= rq ^ 16'hA5C3;
	end
	// Any request with no note queued is a refused access that got through
	always @(posedge clk_sys) begin
		if (mem_req_q.req === 1'b1) begin
			if (exp_q.size() == 0) `CHK(mem_req_q.req, 1'b0)
			else begin
				e = exp_q.pop_front();
				`CHK({mem_req_q.we, mem_req_q.addr, mem_req_q.we ? mem_req_q.wdata : 16'h0000}, e)
			end
		end
		// Host read data owns the bus, so the core must not hold a grant then
		if (main_pins_q.oe_n === 1'b0 && core_drive === 1'b0) `CHK(core_grant_q, 1'b0)
	end
	////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	task automatic report_and_stop;
		if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic taken);
		if (taken) exp_q.push_back({1'b1, a, d});
		host_u.write(a, d);
		tick(2);
	endtask : wr
	task automatic rd_chk(input logic [15:0] a);
		exp_q.push_back({1'b0, a, 16'h0000});
		host_u.read(a, rd, ok);
		if (!ok) begin
			num_errors++;
			report_and_stop;
		end
		`CHK(rd, a ^ 16'hA5C3)
	endtask : rd_chk
	initial begin
		tick(90000);
		num_errors++;
		report_and_stop;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{reset, wide_mode_select, host_port_strap_enable, float_n} = 4'hF;
		{main_keeper_enable, host_keeper_enable, takeover_req, core_drive} = 4'hC;
		{host_byte_drive, mem_rvalid, rv_pipe, mem_rdata, last_q, rq} = '0;
		{core_wdata, host_byte_wdata, gpio_out, gpio_dir, ext_byte} = '0;
		{num_errors, samples_checked} = '0;
		void'($urandom(27));
		tick(5);
		`CHK({main_pins_q.oe_n, main_pins_q.keeper_on, byte_pins_q}, {2'b10, 8'h00, 16'hFF00})
		tick(5);
		reset = 1'b0;
		tick(12);
		`CHK({host_port_en_q, wide_mode_q, core_grant_q}, 3'b111)
		for (int i = 0; i < 6; i++) begin
			ra = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
			wr(ra, 16'($urandom), 1'b1);
			rd_chk(ra);
		end
		{gpio_dir, core_wdata, core_drive} = {8'hFF, 16'($urandom), 1'b1};
		tick(2);
		`CHK({main_pins_q.oe_n, main_pins_q.out}, {1'b0, core_wdata})
		tick(6);
		`CHK(main_data_rd_q, core_wdata)
		takeover_req = 1'b1;
		tick(8);
		`CHK(main_pins_q.oe_n, 1'b1)
		{takeover_req, float_n} = 2'b00;
		tick(8);
		`CHK({main_pins_q.oe_n, byte_pins_q.oe_n}, 9'h1FF)
		{float_n, core_drive} = 2'b10;
		tick(8);
		`CHK({main_pins_q.keeper_on, main_data_pins_in}, {1'b1, core_wdata})
		main_keeper_enable = 1'b0;
		tick(8);
		`CHK(main_pins_q.keeper_on, 1'b0)
		for (int i = 0; i < 4; i++) begin
			{gpio_dir, gpio_out, ext_byte} = 24'($urandom);
			host_keeper_enable = 1'(i % 2);
			tick(8);
			`CHK(byte_pins_q.oe_n, ~gpio_dir)
			`CHK(byte_pins_q.out & gpio_dir, gpio_out & gpio_dir)
			`CHK(byte_pins_q.keeper_on & ~gpio_dir, {8{host_keeper_enable}} & ~gpio_dir)
			if (!host_keeper_enable)
				`CHK(gpio_in_q, (gpio_out & gpio_dir) | (ext_byte & ~gpio_dir))
		end
		{wide_mode_select, host_byte_drive, host_byte_wdata} = {2'b01, 8'($urandom)};
		tick(8);
		`CHK({byte_pins_q.oe_n, byte_pins_q.out}, {8'h00, host_byte_wdata})
		wr(16'h1234, 16'h5678, 1'b0);
		host_byte_drive = 1'b0;
		tick(4);
		`CHK(byte_pins_q.oe_n, 8'hFF)
		{wide_mode_select, host_port_strap_enable, reset} = 3'b101;
		tick(10);
		reset = 1'b0;
		tick(12);
		`CHK(host_port_en_q, 1'b0)
		wr(16'h00A5, 16'h5A5A, 1'b0);
		host_port_strap_enable = 1'b1;
		tick(8);
		`CHK({host_port_en_q, exp_q.size() == 0}, 2'b01)
		report_and_stop;
	end
endmodule : tb_top
`default_nettype wire
